// File: inc/bgsl_if.sv
// Purpose: carrier between register front end, lock and sampler
// Assumes: single clock domain
// Notes: strobes are one-cycle pulses
`timescale 1ns/1ps
interface bgsl_if;
  logic cfg_wr;
  logic [2:0] cfg_val;
  logic guard_busy;
  logic core_on;
  logic buf_on;
  logic sampling;
  logic lock_wr;
  logic lock_arm_w;
  logic lock_set_w;
  logic locked;
  logic lock_arm;
  logic lock_set;
  modport top (output cfg_wr, output cfg_val, output lock_wr,
    output lock_arm_w, output lock_set_w, input guard_busy,
    input core_on, input buf_on, input sampling, input locked,
    input lock_arm, input lock_set);
  modport samp (input cfg_wr, input cfg_val, output guard_busy,
    output core_on, output buf_on, output sampling);
  modport lock (input lock_wr, input lock_arm_w, input lock_set_w,
    output locked, output lock_arm, output lock_set);
endinterface

// File: inc/bgsl_pkg.sv
// Purpose: constants for the reference sample and lock control block
// Assumes: APB with 32-bit data, one register per aligned word
// Notes: register indices are kept, byte address is four times the index
// What this block does
// RULE_01 - sampled mode only in power-down, else continuous
// RULE_02 - sampled mode toggles core and buffer periodically
// RULE_03 - code 000 keeps reference always on
// RULE_04 - code 111 keeps reference off in power-down
// RULE_05 - other codes sample during power-down
// RULE_06 - sample control writes ignored during guard time
// RULE_07 - software waits three slow cycles before power-down
// RULE_08 - trim registers reset only by power-on reset
// RULE_09 - factory trims loaded into trim registers at reset
// RULE_10 - software should leave factory trims alone
// RULE_11 - trims and sample control are lockable
// RULE_12 - sample field in bits 2:0, rest zero
// RULE_13 - codes 001..110 give 1 to 32 ms off
// RULE_14 - lock needs arm+set then set within four cycles
// RULE_15 - locked registers blocked until next hardware reset
// RULE_16 - off timer runs on slow oscillator, config resynchronised
package bgsl_pkg;
  localparam logic [7:0] IDX_SAMPLE = 8'hd1;
  localparam logic [7:0] IDX_TRIM_LIN = 8'hd2;
  localparam logic [7:0] IDX_TRIM_NOM = 8'hd3;
  localparam logic [7:0] IDX_LOCK = 8'hd4;
  localparam logic [7:0] IDX_STATUS = 8'hd5;
  localparam logic [11:0] ADDR_SAMPLE = {2'h0, IDX_SAMPLE, 2'h0};
  localparam logic [11:0] ADDR_TRIM_LIN = {2'h0, IDX_TRIM_LIN, 2'h0};
  localparam logic [11:0] ADDR_TRIM_NOM = {2'h0, IDX_TRIM_NOM, 2'h0};
  localparam logic [11:0] ADDR_LOCK = {2'h0, IDX_LOCK, 2'h0};
  localparam logic [11:0] ADDR_STATUS = {2'h0, IDX_STATUS, 2'h0};
  localparam logic [2:0] SAMPLE_RESET = 3'h0;
  localparam logic [2:0] CFG_CONTINUOUS = 3'h0;
  localparam logic [2:0] CFG_ALWAYS_OFF = 3'h7;
  localparam int TRIM_LIN_RO_BIT = 5;
  localparam logic [1:0] GUARD_ULP_CYCLES = 2'h3;
  localparam logic [1:0] GUARD_CPU_CYCLES = 2'h3;
  localparam logic [2:0] LOCK_WINDOW_CYCLES = 3'h4;
  localparam int OFF_BASE_MS = 1;
  localparam int ULP_HZ_DEFAULT = 32000;
  localparam int ON_ULP_DEFAULT = 2;
  typedef enum logic [1:0] {
    PH_ON = 2'b01,
    PH_OFF = 2'b10
  } bgsl_phase_e;
endpackage

// File: rtl/bgsl_lock.sv
// Purpose: timed two-write lock of the reference registers
// Assumes: lock_wr pulses once per accepted lock register write
// Notes: only a hardware reset opens the lock again
`timescale 1ns/1ps
module bgsl_lock
  import bgsl_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  bgsl_if.lock ifc
);
  typedef struct packed {
    logic locked;
    logic arm;
    logic set;
    logic [2:0] win;
  } bgsl_lock_s;
  bgsl_lock_s st, next_st;

  always_comb begin
    next_st = st;
    if (st.win != 3'h0) begin
      next_st.win = st.win - 3'h1;
    end
    if (ifc.lock_wr && !st.locked) begin
      if (ifc.lock_arm_w && ifc.lock_set_w) begin
        next_st.arm = 1'b1; // [RULE_14]
        next_st.set = 1'b1;
        next_st.win = LOCK_WINDOW_CYCLES;
      end else if (!ifc.lock_arm_w && ifc.lock_set_w &&
                   st.win != 3'h0) begin
        next_st.locked = 1'b1; // [RULE_14] [RULE_11]
        next_st.arm = 1'b0;
        next_st.set = 1'b1;
        next_st.win = 3'h0;
      end else begin
        // a broken sequence starts over
        next_st.arm = ifc.lock_arm_w;
        next_st.set = ifc.lock_set_w;
        next_st.win = 3'h0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st <= '0; // [RULE_15]
    end else begin
      st <= next_st;
    end
  end

  assign ifc.locked = st.locked;
  assign ifc.lock_arm = st.arm;
  assign ifc.lock_set = st.set;
endmodule

// File: rtl/bgsl_sampler.sv
// Purpose: guard time, slow-side config copy and on/off sampling timer
// Assumes: ulp_clk is a level synchronous to clk, far slower than clk
// Notes: the timer advances only on slow oscillator rising edges
`timescale 1ns/1ps
module bgsl_sampler
  import bgsl_pkg::*;
#(
  parameter int ULP_HZ = ULP_HZ_DEFAULT,
  parameter int ON_ULP = ON_ULP_DEFAULT
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic ulp_clk,
  input wire logic pwr_down,
  bgsl_if.samp ifc
);
  localparam int OFF_BASE_ULP = (ULP_HZ * OFF_BASE_MS + 999) / 1000;
  localparam logic [15:0] OFF_BASE = 16'(OFF_BASE_ULP);
  localparam logic [15:0] ON_LAST = 16'(ON_ULP - 1);

  typedef struct packed {
    logic ulp_q;
    logic [2:0] pend;
    logic [2:0] active;
    logic [1:0] gu;
    logic [1:0] gc;
    logic busy;
    bgsl_phase_e phase;
    logic [15:0] tmr;
    logic core;
    logic buf_en;
    logic sampling;
  } bgsl_samp_s;
  bgsl_samp_s st, next_st;
  logic rise;
  logic [15:0] off_last;

  always_comb begin
    rise = ulp_clk && !st.ulp_q;
    off_last = (OFF_BASE << (st.active - 3'h1)) - 16'h1; // [RULE_13]
    next_st = st;
    next_st.ulp_q = ulp_clk;
    // guard: 3 slow edges to pass the value over, then 3 fast cycles
    if (ifc.cfg_wr && !st.busy) begin
      next_st.pend = ifc.cfg_val; // [RULE_06]
      next_st.busy = 1'b1;
      next_st.gu = GUARD_ULP_CYCLES;
      next_st.gc = GUARD_CPU_CYCLES;
    end else if (st.busy && st.gu != 2'h0) begin
      if (rise) begin
        next_st.gu = st.gu - 2'h1;
        if (st.gu == 2'h1) begin
          next_st.active = st.pend; // [RULE_16]
        end
      end
    end else if (st.busy) begin
      next_st.gc = st.gc - 2'h1; // [RULE_06]
      if (st.gc == 2'h1) begin
        next_st.busy = 1'b0;
      end
    end
    if (!pwr_down || st.active == CFG_CONTINUOUS) begin
      next_st.core = 1'b1; // [RULE_01] [RULE_03]
      next_st.buf_en = 1'b1;
      next_st.phase = PH_ON;
      next_st.tmr = 16'h0;
      next_st.sampling = 1'b0;
    end else if (st.active == CFG_ALWAYS_OFF) begin
      next_st.core = 1'b0; // [RULE_04]
      next_st.buf_en = 1'b0;
      next_st.phase = PH_ON;
      next_st.tmr = 16'h0;
      next_st.sampling = 1'b0;
    end else begin
      next_st.sampling = 1'b1; // [RULE_05]
      if (rise) begin
        case (st.phase)
          PH_ON: begin
            if (st.tmr >= ON_LAST) begin
              next_st.phase = PH_OFF; // [RULE_02]
              next_st.tmr = 16'h0;
              next_st.core = 1'b0;
              next_st.buf_en = 1'b0;
            end else begin
              next_st.tmr = st.tmr + 16'h1;
            end
          end
          PH_OFF: begin
            if (st.tmr >= off_last) begin
              next_st.phase = PH_ON; // [RULE_02]
              next_st.tmr = 16'h0;
              next_st.core = 1'b1;
              next_st.buf_en = 1'b1;
            end else begin
              next_st.tmr = st.tmr + 16'h1; // [RULE_16]
            end
          end
          default: begin
            next_st.phase = PH_ON;
            next_st.tmr = 16'h0;
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      // take the pin level so no false edge follows reset
      st <= '{ulp_q: ulp_clk, pend: SAMPLE_RESET, active: SAMPLE_RESET,
              gu: 2'h0, gc: 2'h0, busy: 1'b0, phase: PH_ON,
              tmr: 16'h0, core: 1'b1, buf_en: 1'b1, sampling: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  assign ifc.guard_busy = st.busy;
  assign ifc.core_on = st.core;
  assign ifc.buf_on = st.buf_en;
  assign ifc.sampling = st.sampling;
endmodule

// File: rtl/bgsl_top.sv
// Purpose: APB register front end of the reference sample/lock control
// Assumes: all inputs synchronous to CLOCK; POR_RST also counts as reset
// Notes: one access cycle per transfer, PREADY high in the access phase
`timescale 1ns/1ps
module bgsl_top
  import bgsl_pkg::*;
#(
  parameter int ULP_HZ = ULP_HZ_DEFAULT,
  parameter int ON_ULP = ON_ULP_DEFAULT
)
(
  input wire logic CLOCK,
  input wire logic SYS_RST,
  input wire logic POR_RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [3:0] PSTRB,
  output logic PREADY,
  output logic [31:0] PRDATA,
  output logic PSLVERR,
  input wire logic PWR_DOWN,
  input wire logic ULP_CLK,
  input wire logic [7:0] FACTORY_TRIM_NOMINAL,
  input wire logic [7:0] FACTORY_TRIM_LINEAR,
  output logic [7:0] TRIM_NOMINAL,
  output logic [7:0] TRIM_LINEAR,
  output logic REF_CORE_ON,
  output logic REF_BUFFER_ON
);
  typedef struct packed {
    logic pready;
    logic [7:0] rdata;
    logic slverr;
    logic [7:0] trim_nom;
    logic [7:0] trim_lin;
    logic [2:0] sample_cfg;
    logic cfg_wr;
    logic lock_wr;
    logic lock_arm_w;
    logic lock_set_w;
    logic core;
    logic buf_en;
  } bgsl_top_s;
  bgsl_top_s st, next_st;

  bgsl_if ifc ();
  logic hw_rst;
  logic setup;
  logic wr_now;
  logic mapped;
  logic [7:0] rd_val;
  logic [7:0] lin_w;

  assign hw_rst = SYS_RST || POR_RST;

  bgsl_lock u_lock (
    .clk(CLOCK),
    .rst(hw_rst),
    .ifc(ifc.lock)
  );

  bgsl_sampler #(
    .ULP_HZ(ULP_HZ),
    .ON_ULP(ON_ULP)
  ) u_samp (
    .clk(CLOCK),
    .rst(hw_rst),
    .ulp_clk(ULP_CLK),
    .pwr_down(PWR_DOWN),
    .ifc(ifc.samp)
  );

  assign ifc.cfg_wr = st.cfg_wr;
  assign ifc.cfg_val = st.sample_cfg;
  assign ifc.lock_wr = st.lock_wr;
  assign ifc.lock_arm_w = st.lock_arm_w;
  assign ifc.lock_set_w = st.lock_set_w;

  always_comb begin
    setup = PSEL && !PENABLE;
    wr_now = PSEL && PENABLE && st.pready && PWRITE && PSTRB[0];
    mapped = (PADDR == ADDR_SAMPLE) || (PADDR == ADDR_TRIM_LIN) ||
             (PADDR == ADDR_TRIM_NOM) || (PADDR == ADDR_LOCK) ||
             (PADDR == ADDR_STATUS);
    // locked registers read as zero: no access at all
    case (PADDR)
      ADDR_SAMPLE: rd_val = ifc.locked ? 8'h00 :
                            {5'h00, st.sample_cfg}; // [RULE_12] [RULE_15]
      ADDR_TRIM_LIN: rd_val = ifc.locked ? 8'h00 : st.trim_lin;
      ADDR_TRIM_NOM: rd_val = ifc.locked ? 8'h00 : st.trim_nom;
      ADDR_LOCK: rd_val = {6'h00, ifc.lock_arm, ifc.lock_set};
      ADDR_STATUS: rd_val = {3'h0, ifc.sampling, ifc.locked,
                             ifc.buf_on, ifc.core_on, ifc.guard_busy};
      default: rd_val = 8'h00;
    endcase
    lin_w = PWDATA[7:0];
    lin_w[TRIM_LIN_RO_BIT] = st.trim_lin[TRIM_LIN_RO_BIT];
    next_st = st;
    next_st.pready = setup;
    next_st.cfg_wr = 1'b0;
    next_st.lock_wr = 1'b0;
    next_st.core = ifc.core_on;
    next_st.buf_en = ifc.buf_on;
    if (setup) begin
      next_st.rdata = PWRITE ? 8'h00 : rd_val;
      next_st.slverr = !mapped;
    end else if (PSEL && PENABLE && st.pready) begin
      next_st.rdata = 8'h00;
      next_st.slverr = 1'b0;
    end
    if (wr_now) begin
      case (PADDR)
        ADDR_SAMPLE: begin
          if (!ifc.locked && !ifc.guard_busy) begin // [RULE_06] [RULE_15]
            next_st.sample_cfg = PWDATA[2:0]; // [RULE_12]
            next_st.cfg_wr = 1'b1;
          end
        end
        ADDR_TRIM_LIN: begin
          if (!ifc.locked) begin // [RULE_11]
            next_st.trim_lin = lin_w;
          end
        end
        ADDR_TRIM_NOM: begin
          if (!ifc.locked) begin // [RULE_11]
            next_st.trim_nom = PWDATA[7:0];
          end
        end
        ADDR_LOCK: begin
          next_st.lock_wr = 1'b1; // [RULE_14]
          next_st.lock_arm_w = PWDATA[1];
          next_st.lock_set_w = PWDATA[0];
        end
        default: begin
          next_st.lock_wr = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge CLOCK) begin
    if (POR_RST) begin
      st <= '0;
      st.trim_nom <= FACTORY_TRIM_NOMINAL; // [RULE_08] [RULE_09]
      st.trim_lin <= FACTORY_TRIM_LINEAR;
      st.sample_cfg <= SAMPLE_RESET;
      st.core <= 1'b1;
      st.buf_en <= 1'b1;
    end else if (SYS_RST) begin
      // trims survive every reset but power-on
      st.pready <= 1'b0; // [RULE_08]
      st.rdata <= 8'h00;
      st.slverr <= 1'b0;
      st.sample_cfg <= SAMPLE_RESET;
      st.cfg_wr <= 1'b0;
      st.lock_wr <= 1'b0;
      st.lock_arm_w <= 1'b0;
      st.lock_set_w <= 1'b0;
      st.core <= 1'b1;
      st.buf_en <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign PREADY = st.pready;
  assign PRDATA = {24'h000000, st.rdata};
  assign PSLVERR = st.slverr;
  assign TRIM_NOMINAL = st.trim_nom;
  assign TRIM_LINEAR = st.trim_lin;
  assign REF_CORE_ON = st.core;
  assign REF_BUFFER_ON = st.buf_en;
endmodule

// File: tb/bgsl_bench.sv
// Purpose: self-checking bench for the reference sample and lock control
// Assumes: slow oscillator from the partner, 8 clocks per period
// Notes: rate parameter shrunk so one off unit is 4 slow edges
`timescale 1ns/1ps
module bgsl_bench;
  import bgsl_pkg::*;
  localparam int HZ = 4000;
  localparam int ONU = 2;
  localparam int HALF = 4;
  localparam logic [7:0] FNOM = 8'ha5;
  localparam logic [7:0] FLIN = 8'h3c;
  logic CLOCK = 1'b0;
  logic SYS_RST = 1'b1;
  logic POR_RST = 1'b1;
  logic PSEL = 1'b0;
  logic PENABLE = 1'b0;
  logic PWRITE = 1'b0;
  logic PWR_DOWN = 1'b0;
  logic [11:0] PADDR = 12'h0;
  logic [31:0] PWDATA = 32'h0;
  logic PREADY, PSLVERR, ULP_CLK, REF_CORE_ON, REF_BUFFER_ON, live;
  logic [31:0] PRDATA;
  logic [7:0] TRIM_NOMINAL, TRIM_LINEAR;
  logic [31:0] rd;
  logic er;
  int failures = 0;
  int checks = 0;

  bgsl_top #(.ULP_HZ(HZ), .ON_ULP(ONU)) bgsl_top_i (.CLOCK, .SYS_RST,
    .POR_RST, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PSTRB(4'hf),
    .PREADY, .PRDATA, .PSLVERR, .PWR_DOWN, .ULP_CLK,
    .FACTORY_TRIM_NOMINAL(FNOM), .FACTORY_TRIM_LINEAR(FLIN),
    .TRIM_NOMINAL, .TRIM_LINEAR, .REF_CORE_ON, .REF_BUFFER_ON);
  bgsl_ref_model #(.HALF(HALF)) bgsl_ref_model_i (.clk(CLOCK),
    .core_on(REF_CORE_ON), .buf_on(REF_BUFFER_ON), .slow_clk(ULP_CLK),
    .live(live));

  initial forever #5 CLOCK = ~CLOCK;

  task automatic report_and_stop;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic cmp(input string nm, input logic [31:0] s,
    input logic [31:0] e);
    checks++;
    if (s !== e) begin
      failures++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic hang(input string nm);
    failures++;
    $display("ERROR %s expected done seen timeout", nm);
    report_and_stop();
  endtask

  // one transfer; released one edge before the next setup may start
  task automatic apb(input logic [11:0] a, input logic w,
    input logic [7:0] d);
    int n;
    @(posedge CLOCK);
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= {24'h0, d};
    @(posedge CLOCK);
    PENABLE <= 1'b1;
    n = 0;
    do begin
      @(posedge CLOCK);
      n++;
    end while (PREADY !== 1'b1 && n < 20);
    if (n >= 20) hang("pready");
    rd = PRDATA;
    er = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask

  task automatic rd_chk(input string nm, input logic [11:0] a,
    input logic [31:0] e);
    apb(a, 1'b0, 8'h0);
    cmp(nm, rd, e);
  endtask

  task automatic wait_guard;
    int n;
    n = 0;
    do begin
      apb(ADDR_STATUS, 1'b0, 8'h0);
      n++;
    end while (rd[0] !== 1'b0 && n < 100);
    if (n >= 100) hang("guard");
  endtask

  // an earlier write may still hold the guard, so wait on both sides
  task automatic set_cfg(input logic [2:0] c);
    wait_guard();
    apb(ADDR_SAMPLE, 1'b1, {5'h0, c});
    wait_guard();
  endtask

  task automatic wait_lvl(input logic v, output int n);
    n = 0;
    while (REF_CORE_ON !== v && n < 3000) begin
      @(negedge CLOCK);
      n++;
    end
    if (n >= 3000) hang("ref level");
  endtask

  task automatic wake;
    @(posedge CLOCK);
    PWR_DOWN <= 1'b0;
    repeat (2) @(posedge CLOCK);
    @(negedge CLOCK);
    cmp("wake on", REF_CORE_ON, 32'h1);
    cmp("wake live", live, 32'h1);
  endtask

  task automatic pd_hold(input logic [2:0] c, input logic v);
    int n;
    set_cfg(c);
    PWR_DOWN <= 1'b1;
    repeat (8) @(negedge CLOCK);
    n = 0;
    repeat (300) begin
      @(negedge CLOCK);
      if (REF_CORE_ON !== v) n++;
    end
    cmp("pd hold", n, 0);
    wake();
  endtask

  task automatic t_reset;
    rd_chk("sample rst", ADDR_SAMPLE, 32'h0);
    rd_chk("nom load", ADDR_TRIM_NOM, {24'h0, FNOM});
    rd_chk("lin load", ADDR_TRIM_LIN, {24'h0, FLIN});
    apb(12'h3fc, 1'b0, 8'h0);
    cmp("unmapped", {31'h0, er}, 32'h1);
  endtask

  task automatic t_guard;
    apb(ADDR_SAMPLE, 1'b1, 8'hf9);
    apb(ADDR_SAMPLE, 1'b1, 8'h02);
    rd_chk("guard drop", ADDR_SAMPLE, 32'h1);
    set_cfg(3'h2);
    rd_chk("after guard", ADDR_SAMPLE, 32'h2);
  endtask

  task automatic t_sample;
    int n, off, on;
    for (int c = 1; c <= 6; c++) begin
      set_cfg(c[2:0]);
      PWR_DOWN <= 1'b1;
      wait_lvl(1'b0, n);
      wait_lvl(1'b1, off);
      wait_lvl(1'b0, on);
      cmp("off time", off,
          ((HZ + 999) / 1000 << (c - 1)) * 2 * HALF);
      cmp("on time", on, ONU * 2 * HALF);
      wake();
    end
    pd_hold(3'h7, 1'b0);
    pd_hold(3'h0, 1'b1);
  endtask

  task automatic t_trim;
    set_cfg(3'h3);
    apb(ADDR_TRIM_NOM, 1'b1, 8'h5a);
    apb(ADDR_TRIM_LIN, 1'b1, 8'h00);
    @(negedge CLOCK);
    cmp("nom wr", {24'h0, TRIM_NOMINAL}, 32'h5a);
    cmp("lin ro bit", {24'h0, TRIM_LINEAR}, {24'h0, FLIN & 8'h20});
    @(posedge CLOCK);
    SYS_RST <= 1'b1;
    @(posedge CLOCK);
    SYS_RST <= 1'b0;
    @(negedge CLOCK);
    cmp("nom kept", {24'h0, TRIM_NOMINAL}, 32'h5a);
    cmp("lin kept", {24'h0, TRIM_LINEAR}, {24'h0, FLIN & 8'h20});
    rd_chk("sample cleared", ADDR_SAMPLE, 32'h0);
    POR_RST <= 1'b1;
    @(posedge CLOCK);
    POR_RST <= 1'b0;
    @(negedge CLOCK);
    // factory trims restored, t_lock later writes the nominal trim again
    cmp("nom por", {24'h0, TRIM_NOMINAL}, {24'h0, FNOM});
    cmp("lin por", {24'h0, TRIM_LINEAR}, {24'h0, FLIN});
  endtask

  task automatic t_lock;
    apb(ADDR_LOCK, 1'b1, 8'h3);
    repeat (6) @(posedge CLOCK);
    apb(ADDR_LOCK, 1'b1, 8'h1);
    apb(ADDR_TRIM_NOM, 1'b1, 8'h11);
    @(negedge CLOCK);
    cmp("late unlocked", {24'h0, TRIM_NOMINAL}, 32'h11);
    apb(ADDR_LOCK, 1'b1, 8'h3);
    apb(ADDR_LOCK, 1'b1, 8'h1);
    apb(ADDR_STATUS, 1'b0, 8'h0);
    cmp("locked", {31'h0, rd[3]}, 32'h1);
    apb(ADDR_TRIM_NOM, 1'b1, 8'h22);
    @(negedge CLOCK);
    cmp("nom blocked", {24'h0, TRIM_NOMINAL}, 32'h11);
    rd_chk("locked read", ADDR_TRIM_NOM, 32'h0);
    apb(ADDR_SAMPLE, 1'b1, 8'h7);
    PWR_DOWN <= 1'b1;
    repeat (60) @(negedge CLOCK);
    cmp("cfg blocked", REF_CORE_ON, 32'h1);
    wake();
    @(posedge CLOCK);
    SYS_RST <= 1'b1;
    @(posedge CLOCK);
    SYS_RST <= 1'b0;
    apb(ADDR_TRIM_NOM, 1'b1, 8'h33);
    @(negedge CLOCK);
    cmp("reopened", {24'h0, TRIM_NOMINAL}, 32'h33);
  endtask

  initial begin
    repeat (16) @(posedge CLOCK);
    SYS_RST <= 1'b0;
    POR_RST <= 1'b0;
    t_reset();
    t_guard();
    t_sample();
    t_trim();
    t_lock();
    report_and_stop();
  end
endmodule

bind bgsl_top bgsl_chk #(.ULP_HZ(ULP_HZ), .ON_ULP(ON_ULP)) bgsl_chk_i (
  .CLOCK, .SYS_RST, .POR_RST, .PSEL, .PENABLE, .PWRITE, .PREADY, .PRDATA,
  .PSLVERR, .PWR_DOWN, .FACTORY_TRIM_NOMINAL, .FACTORY_TRIM_LINEAR,
  .TRIM_NOMINAL, .TRIM_LINEAR, .REF_CORE_ON, .REF_BUFFER_ON);

// File: tb/bgsl_chk.sv
// Purpose: port checks for the reference sample and lock control
// Assumes: one clock, both resets synchronous and active high
// Notes: lock state is not visible here, the bench judges it
`timescale 1ns/1ps
module bgsl_chk
  import bgsl_pkg::*;
#(
  parameter int ULP_HZ = ULP_HZ_DEFAULT,
  parameter int ON_ULP = ON_ULP_DEFAULT
)
(
  input wire logic CLOCK,
  input wire logic SYS_RST,
  input wire logic POR_RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic PREADY,
  input wire logic [31:0] PRDATA,
  input wire logic PSLVERR,
  input wire logic PWR_DOWN,
  input wire logic [7:0] FACTORY_TRIM_NOMINAL,
  input wire logic [7:0] FACTORY_TRIM_LINEAR,
  input wire logic [7:0] TRIM_NOMINAL,
  input wire logic [7:0] TRIM_LINEAR,
  input wire logic REF_CORE_ON,
  input wire logic REF_BUFFER_ON
);
  default clocking @(posedge CLOCK);
  endclocking
  chk_ready_next: assert property (disable iff (SYS_RST || POR_RST)
    PSEL && !PENABLE |=> PREADY) else $error("no ready after setup");
  chk_ready_once: assert property (disable iff (SYS_RST || POR_RST)
    PREADY |=> !PREADY) else $error("ready held too long");
  chk_ready_cause: assert property (disable iff (SYS_RST || POR_RST)
    PREADY |-> $past(PSEL) && !$past(PENABLE))
    else $error("ready without setup");
  chk_err_ready: assert property (disable iff (SYS_RST || POR_RST)
    PSLVERR |-> PREADY) else $error("error outside access");
  chk_rdata_width: assert property (
    disable iff (SYS_RST || POR_RST)
    PREADY |-> PRDATA[31:8] == 24'h0) else $error("upper data set");
  chk_ref_pair: assert property (
    disable iff (SYS_RST || POR_RST)
    REF_CORE_ON == REF_BUFFER_ON) else $error("core and buffer differ");
  chk_wake_on: assert property (
    disable iff (SYS_RST || POR_RST)
    !PWR_DOWN [*4] |-> REF_CORE_ON) else $error("off while awake");
  chk_por_load: assert property (
    disable iff (SYS_RST)
    POR_RST |=> TRIM_NOMINAL == $past(FACTORY_TRIM_NOMINAL) &&
    TRIM_LINEAR == $past(FACTORY_TRIM_LINEAR)) else $error("trim not loaded");
  chk_trim_keep: assert property (
    disable iff (POR_RST)
    !POR_RST && !(PSEL && PENABLE && PWRITE) |=> $stable(TRIM_NOMINAL) &&
    $stable(TRIM_LINEAR)) else $error("trim changed without write");
endmodule

// File: tb/bgsl_ref_model.sv
// Purpose: slow oscillator and analogue reference stand-in
// Assumes: slow clock is a level that changes right after a fast edge
// Notes: period fixed at two HALF spans of the fast clock
`timescale 1ns/1ps
module bgsl_ref_model #(
  parameter int HALF = 4
)
(
  input wire logic clk,
  input wire logic core_on,
  input wire logic buf_on,
  output logic slow_clk,
  output logic live
);
  int cnt = 0;
  initial slow_clk = 1'b0;
  always @(posedge clk) begin
    if (cnt == HALF - 1) begin
      cnt <= 0;
      slow_clk <= !slow_clk;
    end else begin
      cnt <= cnt + 1;
    end
  end
  // reference only usable with both halves running
  assign live = core_on && buf_on;
endmodule
